// >>> async_serial_port.v
// Asynchronous serial port with AXI4-Lite registers, DMA handshake and interrupt.
//
// Operation
// - RS232-compatible asynchronous frames with a partner.
// - Bit rate at most one sixteenth system clock.
// - Serial clock from system clock or pin.
// - DMA peripheral for receive and transmit data.
// - Loopback routes transmit into receiver internally.
// - Auto echo retransmits every received bit.
// - Resynchronise automatically after a line break.
// - Discard start bits that do not hold.
// - Incoming handshake holds off transmission in hardware.
// - Outgoing handshake driven from receive state.
// - Pulse mode turns transmitter into modulator.
//
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "uart_consts.vh"
module async_serial_port (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        serial_in,
   output reg         serial_out,
   input  wire        ext_serial_clk,
   input  wire        clear_to_send_n,
   output reg         request_to_send_n,
   output wire        dma_rx_req,
   input  wire        dma_rx_ack,
   output wire [7:0]  dma_rx_data,
   output wire        dma_tx_req,
   input  wire        dma_tx_valid,
   input  wire [7:0]  dma_tx_data,
   output wire        irq
);
   localparam [3:0] T_IDLE = 4'b0001, T_START = 4'b0010;
   localparam [3:0] T_DATA = 4'b0100, T_STOP  = 4'b1000;
   reg  [31:0] ctrl_q, w_data_q;
   reg  [15:0] div_q, div_cnt_q;
   reg  [`ST_W-1:0] status_q, mask_q;
   reg  [7:0]  tx_hold_q, rx_hold_q, tx_shift_q, aw_addr_q;
   reg  [3:0]  tx_state_q, tx_os_q, tx_bit_q;
   reg  [1:0]  rx_sync_q, cts_sync_q;
   reg  [2:0]  eck_sync_q;
   reg         tx_full_q, rx_full_q, tick_q, tx_bit_out_q, tx_done_q, aw_have_q, w_have_q;
   wire [7:0]  rx_data;
   wire        rx_done, rx_false, rx_break, rx_ferr, rx_busy, rx_line;
   wire        ext_edge, wr_fire, rd_fire;
   wire [`ST_W-1:0] st_set, st_clr;
   wire [3:0]  char_len = ctrl_q[`CTRL_LEN_LO+3:`CTRL_LEN_LO];

   // Register decode shared by both bus directions.
   function [2:0] reg_sel;
      input [7:0] a;
      begin
         if (a == `OFF_CTRL)        reg_sel = 3'd1;
         else if (a == `OFF_DIV)    reg_sel = 3'd2;
         else if (a == `OFF_STATUS) reg_sel = 3'd3;
         else if (a == `OFF_MASK)   reg_sel = 3'd4;
         else if (a == `OFF_TXDATA) reg_sel = 3'd5;
         else if (a == `OFF_RXDATA) reg_sel = 3'd6;
         else                       reg_sel = 3'd0;
      end
   endfunction

   // ==========================================================================
   // Input synchronisers
   // Pins cross into the clock domain through two flops before any use.
   always @(posedge aclk) begin
      if (!aresetn) begin
         rx_sync_q  <= 2'b11;
         cts_sync_q <= 2'b11;
         eck_sync_q <= 3'b000;
      end else begin
         rx_sync_q  <= {rx_sync_q[0], serial_in};
         cts_sync_q <= {cts_sync_q[0], clear_to_send_n};
         eck_sync_q <= {eck_sync_q[1:0], ext_serial_clk};
      end
   end
   // Edge detect looks only at the second and third stage.
   assign ext_edge = eck_sync_q[1] & ~eck_sync_q[2];

   // ==========================================================================
   // Oversample tick generation
   // A tick is one sixteenth of a bit, so the rate stays within aclk/16.
   // The pin clock must stay below aclk/2 for the edge detector.
   always @(posedge aclk) begin
      if (!aresetn) begin
         div_cnt_q <= 16'h0000;
         tick_q    <= 1'b0;
      end else begin
         tick_q <= 1'b0;
         if (!ctrl_q[`CTRL_EXTCLK] || ext_edge) begin
            if (div_cnt_q >= div_q - 16'h0001) begin
               div_cnt_q <= 16'h0000;
               tick_q    <= 1'b1;
            end else begin
               div_cnt_q <= div_cnt_q + 16'h0001;
            end
         end
      end
   end

   // Loopback feeds the transmitter straight into the receiver.
   assign rx_line = ctrl_q[`CTRL_LOOP] ? tx_bit_out_q : rx_sync_q[1];

   uart_rx u_rx (
      .aclk           (aclk),
      .aresetn        (aresetn & ctrl_q[`CTRL_EN]),
      .tick           (tick_q),
      .rx_line        (rx_line),
      .char_len       (char_len),
      .rx_data_q      (rx_data),
      .rx_done_q      (rx_done),
      .rx_false_q     (rx_false),
      .rx_break_q     (rx_break),
      .rx_frame_err_q (rx_ferr),
      .rx_busy        (rx_busy)
   );

   // ==========================================================================
   // Transmitter
   // Frames: low start, LSB first, one or two high stops, idle high.
   // In pulse mode no start or stop bits are sent, so the line follows the
   // data pattern alone and the duty cycle is set by length, rate and bits.
   always @(posedge aclk) begin
      tx_done_q <= 1'b0;
      if (!aresetn || !ctrl_q[`CTRL_EN]) begin
         tx_state_q   <= T_IDLE;
         tx_os_q      <= 4'h0;
         tx_bit_q     <= 4'h0;
         tx_shift_q   <= 8'h00;
         tx_bit_out_q <= 1'b1;
      end else if (tick_q) begin
         case (tx_state_q)
            T_IDLE: begin
               tx_bit_out_q <= 1'b1;
               // Clear-to-send high holds off a new frame in hardware.
               if (tx_full_q && !(ctrl_q[`CTRL_HWFLOW] && cts_sync_q[1])) begin
                  tx_shift_q <= tx_hold_q;
                  tx_os_q    <= 4'h0;
                  tx_bit_q   <= 4'h0;
                  if (ctrl_q[`CTRL_PULSE]) begin
                     tx_state_q   <= T_DATA;
                     tx_bit_out_q <= tx_hold_q[0];
                  end else begin
                     tx_state_q   <= T_START;
                     tx_bit_out_q <= 1'b0;
                  end
               end
            end
            T_START: begin
               tx_os_q <= tx_os_q + 4'h1;
               if (tx_os_q == 4'hf) begin
                  tx_state_q   <= T_DATA;
                  tx_bit_out_q <= tx_shift_q[0];
               end
            end
            T_DATA: begin
               tx_os_q <= tx_os_q + 4'h1;
               if (tx_os_q == 4'hf) begin
                  tx_bit_q   <= tx_bit_q + 4'h1;
                  tx_shift_q <= {1'b0, tx_shift_q[7:1]};
                  if (tx_bit_q == char_len - 4'h1) begin
                     if (ctrl_q[`CTRL_PULSE]) begin
                        tx_state_q <= T_IDLE;
                        tx_done_q  <= 1'b1;
                        tx_bit_out_q <= 1'b1;
                     end else begin
                        tx_state_q   <= T_STOP;
                        tx_bit_out_q <= 1'b1;
                     end
                  end else begin
                     tx_bit_out_q <= tx_shift_q[1];
                  end
               end
            end
            default: begin
               tx_os_q <= tx_os_q + 4'h1;
               if (tx_os_q == 4'hf) begin
                  if (ctrl_q[`CTRL_TWOSTOP] && tx_bit_q == char_len) begin
                     tx_bit_q <= tx_bit_q + 4'h1;
                  end else begin
                     tx_state_q <= T_IDLE;
                     tx_done_q  <= 1'b1;
                  end
               end
            end
         endcase
      end
   end

   // Line driver: echo sends received bits back out, else transmitter.
   // Request-to-send deasserts while receive data waits unread.
   always @(posedge aclk) begin
      if (!aresetn) begin
         serial_out        <= 1'b1;
         request_to_send_n <= 1'b1;
      end else begin
         serial_out        <= ctrl_q[`CTRL_ECHO] ? rx_sync_q[1] : tx_bit_out_q;
         request_to_send_n <= ctrl_q[`CTRL_HWFLOW] ? rx_full_q : 1'b0;
      end
   end

   // ==========================================================================
   // AXI4-Lite slave
   assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_have_q & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   assign wr_fire = aw_have_q & w_have_q;
   assign rd_fire = s_axi_arvalid & s_axi_arready;

   // Status bits are sticky; a new event wins over a write-one clear.
   assign st_set = {rx_done & rx_full_q, rx_ferr, rx_false, rx_break, tx_done_q, rx_done};
   assign st_clr = (wr_fire && reg_sel(aw_addr_q) == 3'd3) ? w_data_q[`ST_W-1:0]
                                                           : {`ST_W{1'b0}};
   assign irq = |(status_q & mask_q);

   // Transmit holding word fills from software or DMA.
   assign dma_tx_req  = ctrl_q[`CTRL_DMA] & ~tx_full_q;
   assign dma_rx_req  = ctrl_q[`CTRL_DMA] & rx_full_q;
   assign dma_rx_data = rx_hold_q;

   // Bus channels, register writes and receive/transmit holding registers.
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q    <= 1'b0;
         w_have_q     <= 1'b0;
         aw_addr_q    <= 8'h00;
         w_data_q     <= 32'h0000_0000;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= 2'b00;
         s_axi_rdata  <= 32'h0000_0000;
         ctrl_q       <= `CTRL_RESET;
         div_q        <= `DIV_RESET;
         status_q     <= {`ST_W{1'b0}};
         mask_q       <= {`ST_W{1'b0}};
         tx_hold_q    <= 8'h00;
         tx_full_q    <= 1'b0;
         rx_hold_q    <= 8'h00;
         rx_full_q    <= 1'b0;
      end else begin
         status_q <= (status_q & ~st_clr) | st_set;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                                       {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
         end
         if (tick_q && tx_state_q == T_IDLE && tx_full_q &&
             !(ctrl_q[`CTRL_HWFLOW] && cts_sync_q[1]))
            tx_full_q <= 1'b0;
         if (dma_tx_req && dma_tx_valid) begin
            tx_hold_q <= dma_tx_data;
            tx_full_q <= 1'b1;
         end
         if (rx_done) begin
            rx_hold_q <= rx_data;
            rx_full_q <= 1'b1;
         end else if (dma_rx_req && dma_rx_ack) begin
            rx_full_q <= 1'b0;
         end
         if (wr_fire) begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= 2'b00;
            if (reg_sel(aw_addr_q) == 3'd1) begin
               ctrl_q <= w_data_q;
            end else if (reg_sel(aw_addr_q) == 3'd2) begin
               div_q <= (w_data_q[15:0] == 16'h0000) ? `DIV_MIN : w_data_q[15:0];
            end else if (reg_sel(aw_addr_q) == 3'd4) begin
               mask_q <= w_data_q[`ST_W-1:0];
            end else if (reg_sel(aw_addr_q) == 3'd5) begin
               if (!tx_full_q) begin
                  tx_hold_q <= w_data_q[7:0];
                  tx_full_q <= 1'b1;
               end
            end else if (reg_sel(aw_addr_q) == 3'd0) begin
               s_axi_bresp <= 2'b10;
            end
         end
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'b00;
            s_axi_rdata  <= 32'h0000_0000;
            if (reg_sel(s_axi_araddr) == 3'd1) begin
               s_axi_rdata <= ctrl_q;
            end else if (reg_sel(s_axi_araddr) == 3'd2) begin
               s_axi_rdata <= {16'h0000, div_q};
            end else if (reg_sel(s_axi_araddr) == 3'd3) begin
               s_axi_rdata <= {22'h000000, rx_busy, ~tx_state_q[0], tx_full_q,
                               rx_full_q, status_q};
            end else if (reg_sel(s_axi_araddr) == 3'd4) begin
               s_axi_rdata <= {26'h0000000, mask_q};
            end else if (reg_sel(s_axi_araddr) == 3'd6) begin
               s_axi_rdata <= {24'h000000, rx_hold_q};
               if (!rx_done) rx_full_q <= 1'b0;
            end else if (reg_sel(s_axi_araddr) == 3'd0) begin
               s_axi_rresp <= 2'b10;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule // async_serial_port
`default_nettype wire

// >>> uart_consts.vh
// Register map, field positions, reset values and timing constants of the serial port.
`ifndef UART_CONSTS_VH
`define UART_CONSTS_VH
// ==========================================================================
// Register byte offsets
`define OFF_CTRL      8'h00
`define OFF_DIV       8'h04
`define OFF_STATUS    8'h08
`define OFF_MASK      8'h0c
`define OFF_TXDATA    8'h10
`define OFF_RXDATA    8'h14
// ==========================================================================
// Control register fields
`define CTRL_EN       0
`define CTRL_EXTCLK   1
`define CTRL_LOOP     2
`define CTRL_ECHO     3
`define CTRL_HWFLOW   4
`define CTRL_PULSE    5
`define CTRL_TWOSTOP  6
`define CTRL_DMA      7
`define CTRL_LEN_LO   8
`define CTRL_RESET    32'h0000_0801
// ==========================================================================
// Status register fields (sticky, write one to clear)
`define ST_RXRDY      0
`define ST_TXDONE     1
`define ST_BREAK      2
`define ST_FALSE      3
`define ST_FRAME      4
`define ST_OVERRUN    5
`define ST_W          6
// ==========================================================================
// Timing
`define OVERSAMPLE    16
`define DIV_MIN       16'h0001
`define DIV_RESET     16'h000d
`endif

// >>> uart_rx.v
// Serial receiver with sixteen-times oversampling, false start and break handling.
`timescale 1ns/1ps
`default_nettype none
`include "uart_consts.vh"
module uart_rx (
   input  wire       aclk,
   input  wire       aresetn,
   input  wire       tick,
   input  wire       rx_line,
   input  wire [3:0] char_len,
   output reg  [7:0] rx_data_q,
   output reg        rx_done_q,
   output reg        rx_false_q,
   output reg        rx_break_q,
   output reg        rx_frame_err_q,
   output wire       rx_busy
);
   localparam [3:0] S_IDLE  = 4'b0001;
   localparam [3:0] S_START = 4'b0010;
   localparam [3:0] S_DATA  = 4'b0100;
   localparam [3:0] S_STOP  = 4'b1000;
   reg [3:0] state_q;
   reg [3:0] os_q;
   reg [3:0] bit_q;
   reg [7:0] shift_q;
   reg       all_zero_q;
   reg       brk_wait_q;
   assign rx_busy = ~state_q[0];
   // ==========================================================================
   // Receive state machine
   // Sampling at sixteen ticks per bit and taking the eighth tick lands mid-bit.
   always @(posedge aclk) begin
      rx_done_q      <= 1'b0;
      rx_false_q     <= 1'b0;
      rx_break_q     <= 1'b0;
      rx_frame_err_q <= 1'b0;
      if (!aresetn) begin
         state_q    <= S_IDLE;
         os_q       <= 4'h0;
         bit_q      <= 4'h0;
         shift_q    <= 8'h00;
         rx_data_q  <= 8'h00;
         all_zero_q <= 1'b0;
         brk_wait_q <= 1'b0;
      end else if (tick) begin
         case (state_q)
            S_IDLE: begin
               // After a break, wait for the line to return high first.
               if (brk_wait_q) begin
                  if (rx_line) brk_wait_q <= 1'b0;
               end else if (!rx_line) begin
                  state_q <= S_START;
                  os_q    <= 4'h0;
               end
            end
            S_START: begin
               os_q <= os_q + 4'h1;
               if (os_q == 4'h7) begin
                  // A start bit gone high by mid-bit is a glitch.
                  if (rx_line) begin
                     state_q    <= S_IDLE;
                     rx_false_q <= 1'b1;
                  end else begin
                     state_q    <= S_DATA;
                     os_q       <= 4'h0;
                     bit_q      <= 4'h0;
                     all_zero_q <= 1'b1;
                  end
               end
            end
            S_DATA: begin
               os_q <= os_q + 4'h1;
               if (os_q == 4'hf) begin
                  // Data arrives least significant bit first.
                  shift_q    <= {rx_line, shift_q[7:1]};
                  all_zero_q <= all_zero_q & ~rx_line;
                  bit_q      <= bit_q + 4'h1;
                  if (bit_q == char_len - 4'h1) state_q <= S_STOP;
               end
            end
            default: begin
               os_q <= os_q + 4'h1;
               if (os_q == 4'hf) begin
                  state_q   <= S_IDLE;
                  rx_data_q <= shift_q >> (4'd8 - char_len);
                  if (rx_line) begin
                     rx_done_q <= 1'b1;
                  end else if (all_zero_q) begin
                     rx_break_q <= 1'b1;
                     brk_wait_q <= 1'b1;
                  end else begin
                     rx_frame_err_q <= 1'b1;
                  end
               end
            end
         endcase
      end
   end
endmodule // uart_rx
`default_nettype wire

// >>> async_serial_port_properties.sv
// Bus handshake, serial timing and DMA handshake properties of the serial port.
`timescale 1ns/1ps
`default_nettype none
module async_serial_port_properties (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic serial_out,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic dma_rx_req,
   input wire logic dma_rx_ack,
   input wire logic dma_tx_req,
   input wire logic dma_tx_valid
);
   logic [4:0] run_q;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ==========================================================================
   // Cycles the pin has held its level; saturates so a long idle never wraps.
   always_ff @(posedge aclk) begin
      if (!aresetn)
         run_q <= 5'd16;
      else if (serial_out != $past(serial_out))
         run_q <= 5'd1;
      else if (run_q != 5'd31)
         run_q <= run_q + 5'd1;
   end
   chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer not two cycles later");
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   chk_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted during response");
   chk_read_gate: assert property (s_axi_arready == !s_axi_rvalid)
      else $error("read ready not inverse of valid");
   chk_idle_level: assert property ($rose(aresetn) |-> serial_out)
      else $error("pin not idle high after reset");
   chk_bit_length: assert property ($changed(serial_out) |-> run_q >= 5'd16)
      else $error("serial bit shorter than sixteen clocks");
   chk_dma_rx_take: assert property (dma_rx_req && dma_rx_ack |=> !dma_rx_req)
      else $error("receive request kept after take");
   chk_dma_tx_take: assert property (dma_tx_req && dma_tx_valid |=> !dma_tx_req)
      else $error("transmit request kept after load");
endmodule // async_serial_port_properties
bind async_serial_port async_serial_port_properties i_chk (.aclk, .aresetn, .serial_out,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .dma_rx_req, .dma_rx_ack, .dma_tx_req,
   .dma_tx_valid);
`default_nettype wire

// >>> serial_partner.sv
// Behavioural far-side serial device that sends and receives frames.
`timescale 1ns/1ps
`default_nettype none
module serial_partner (
   input  wire logic aclk,
   input  wire logic tx_line,
   output var  logic rx_line
);
   int bit_cyc = 16;
   // ==========================================================================
   // The line rests high between frames.
   initial rx_line = 1'b1;
   // Holds one level for a number of clocks, changing just after an edge.
   task automatic drive(input logic v, input int n);
      rx_line <= v;
      repeat (n) @(posedge aclk);
   endtask
   // Low start, eight data bits from the low end, one high stop.
   task automatic send(input logic [7:0] v);
      drive(1'b0, bit_cyc);
      for (int i = 0; i < 8; i++) drive(v[i], bit_cyc);
      drive(1'b1, bit_cyc);
   endtask
   // Waits a bounded time for a start, then samples each bit at its middle.
   task automatic recv(output logic [7:0] v);
      int n;
      n = 0;
      v = 8'hxx;
      while (tx_line && n < 20000) begin
         @(posedge aclk);
         n++;
      end
      repeat (bit_cyc / 2) @(posedge aclk);
      for (int i = 0; i < 8 && n < 20000; i++) begin
         repeat (bit_cyc) @(posedge aclk);
         v[i] = tx_line;
      end
   endtask
endmodule // serial_partner
`default_nettype wire

// >>> async_serial_port_tb.sv
// Self-checking testbench of the serial port: registers, link, modes and DMA.
`timescale 1ns/1ps
`default_nettype none
`include "uart_consts.vh"
module async_serial_port_tb;
   logic        aclk = 0, aresetn = 0, ext_serial_clk = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
   logic        s_axi_bready = 1, s_axi_arvalid = 0, s_axi_rready = 1, clear_to_send_n = 0;
   logic        dma_rx_ack = 0, dma_tx_valid = 0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, dma_tx_data = 8'h00, b;
   logic [31:0] s_axi_wdata = 32'h0, d;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [1:0]  rr;
   wire  [31:0] s_axi_rdata;
   wire  [7:0]  dma_rx_data;
   wire  [1:0]  s_axi_bresp, s_axi_rresp;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire         serial_in, serial_out, request_to_send_n, dma_rx_req, dma_tx_req, irq;
   int          error_cnt = 0, num_checks = 0, n;
   // ==========================================================================
   // The pin clock runs at a quarter of the system clock, below half of it.
   always #20 aclk = ~aclk;
   always #80 ext_serial_clk = ~ext_serial_clk;
   async_serial_port i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_in, .serial_out, .ext_serial_clk,
      .clear_to_send_n, .request_to_send_n, .dma_rx_req, .dma_rx_ack, .dma_rx_data,
      .dma_tx_req, .dma_tx_valid, .dma_tx_data, .irq);
   serial_partner i_peer (.aclk, .tx_line(serial_out), .rx_line(serial_in));
   // A wait that used up its bound ends the run as a mismatch.
   task automatic lim(input logic bad);
      if (bad) begin
         error_cnt++;
         finish_test();
      end
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   // Address and data go together, each dropped once taken; bready, rready stay high.
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      int k;
      k = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
      do begin
         @(posedge aclk);
         k++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && k < 500);
      lim(k >= 500);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
      int k;
      k = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         k++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && k < 500);
      v = s_axi_rdata;
      r = s_axi_rresp;
      lim(k >= 500);
   endtask
   task automatic wst(input int bit_no);
      int k;
      k = 0;
      do begin
         rd(`OFF_STATUS, d, rr);
         k++;
      end while (!d[bit_no] && k < 300);
      lim(k >= 300);
   endtask
   task automatic get_rx(input logic [7:0] v);
      wst(`ST_RXRDY);
      rd(`OFF_RXDATA, d, rr);
      chk(d & 32'hff, {24'h0, v});
   endtask
   // Empties the receive word and clears all events before a new mode.
   task automatic mode(input logic [31:0] c);
      rd(`OFF_RXDATA, d, rr);
      wr(`OFF_STATUS, 32'h3f);
      wr(`OFF_CTRL, c);
   endtask
   task automatic lows(input int c, output int cnt);
      cnt = 0;
      repeat (c) begin
         @(posedge aclk);
         cnt += !serial_out;
      end
   endtask
   task automatic wdma(input logic rx_side);
      int k;
      k = 0;
      while (!(rx_side ? dma_rx_req : dma_tx_req) && k < 500) begin
         @(posedge aclk);
         k++;
      end
      lim(k >= 500);
   endtask
   // ==========================================================================
   // Scenarios.
   task automatic t_regs;
      rd(`OFF_CTRL, d, rr);
      chk(d, `CTRL_RESET);
      rd(8'h40, d, rr);
      chk({30'h0, rr}, 32'h2);
      chk({31'h0, request_to_send_n}, 32'h0);
      wr(`OFF_DIV, 32'h0);
      rd(`OFF_DIV, d, rr);
      chk(d, {16'h0, `DIV_MIN});
      wr(`OFF_MASK, 32'h3f);
   endtask
   task automatic t_tx_irq;
      wr(`OFF_TXDATA, 32'ha5);
      i_peer.recv(b);
      chk({24'h0, b}, 32'ha5);
      wst(`ST_TXDONE);
      chk({31'h0, irq}, 32'h1);
      wr(`OFF_MASK, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr(`OFF_MASK, 32'h3f);
      wr(`OFF_STATUS, 32'h3f);
      chk({31'h0, irq}, 32'h0);
   endtask
   task automatic t_rx_false_break;
      i_peer.send(8'h3c);
      get_rx(8'h3c);
      mode(32'h801);
      i_peer.drive(1'b0, 4);
      i_peer.drive(1'b1, 64);
      rd(`OFF_STATUS, d, rr);
      chk(d & 32'h9, 32'h8);
      i_peer.drive(1'b0, 200);
      i_peer.drive(1'b1, 32);
      rd(`OFF_STATUS, d, rr);
      chk(d & 32'h4, 32'h4);
      mode(32'h801);
      i_peer.send(8'h5a);
      get_rx(8'h5a);
   endtask
   task automatic t_loop_echo;
      mode(32'h745);
      wr(`OFF_TXDATA, 32'h69);
      get_rx(8'h69);
      mode(32'h809);
      fork
         i_peer.send(8'h81);
         i_peer.recv(b);
      join
      chk({24'h0, b}, 32'h81);
   endtask
   task automatic t_flow;
      mode(32'h811);
      clear_to_send_n <= 1'b1;
      wr(`OFF_TXDATA, 32'h96);
      lows(400, n);
      chk(n, 0);
      clear_to_send_n <= 1'b0;
      i_peer.recv(b);
      chk({24'h0, b}, 32'h96);
      i_peer.send(8'h11);
      wst(`ST_RXRDY);
      chk({31'h0, request_to_send_n}, 32'h1);
      rd(`OFF_RXDATA, d, rr);
      repeat (3) @(posedge aclk);
      chk({31'h0, request_to_send_n}, 32'h0);
   endtask
   task automatic t_dma;
      mode(32'h881);
      wdma(1'b0);
      dma_tx_data <= 8'h17;
      dma_tx_valid <= 1'b1;
      @(posedge aclk);
      dma_tx_valid <= 1'b0;
      i_peer.recv(b);
      chk({24'h0, b}, 32'h17);
      i_peer.send(8'h42);
      wdma(1'b1);
      chk({24'h0, dma_rx_data}, 32'h42);
      dma_rx_ack <= 1'b1;
      @(posedge aclk);
      dma_rx_ack <= 1'b0;
   endtask
   task automatic t_pulse_ext;
      mode(32'h821);
      wr(`OFF_TXDATA, 32'hf0);
      lows(400, n);
      chk(n, 64);
      mode(32'h803);
      i_peer.bit_cyc = 64;
      wr(`OFF_TXDATA, 32'hc3);
      i_peer.recv(b);
      chk({24'h0, b}, 32'hc3);
   endtask
   task automatic finish_test;
      $display("mismatches %0d comparisons %0d", error_cnt, num_checks);
      if (error_cnt == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs();
      t_tx_irq();
      t_rx_false_break();
      t_loop_echo();
      t_flow();
      t_dma();
      t_pulse_ext();
      finish_test();
   end
endmodule // async_serial_port_tb
`default_nettype wire
